// ==== src/synth_latch_powerdown_ctrl.sv ====
// Latch bank and power-down control of an integer-N synthesizer.
// Assumes a host drives the three-wire link and a reference-divider tick input.
`timescale 1ns/1ps
module synth_latch_powerdown_ctrl (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic serial_clock,
	input wire logic serial_data,
	input wire logic latch_strobe,
	input wire logic chip_enable,
	input wire logic ref_divider_tick,
	input wire logic lock_detect_raw,
	output logic [23:0] control_word,
	output logic [23:0] feedback_word,
	output logic [23:0] reference_word,
	output logic powered_down,
	output logic counters_load,
	output logic pump_tristate,
	output logic lock_detect,
	output logic rf_output_enable,
	output logic ref_buffer_enable,
	output logic band_select_busy,
	output logic [1:0] prescaler_sel,
	output logic [synth_pkg::fb_b_width-1:0] b_count,
	output logic [synth_pkg::fb_a_width-1:0] a_count,
	output logic [synth_pkg::ref_div_width-1:0] ref_divide
);
	import synth_pkg::*;

	latch_write_if wr ();
	pd_state_t pd_q;
	logic [1:0] ce_sync_q, tick_sync_q, lock_sync_q;
	logic tick_prev_q, awake_q, band_pending_q;
	logic [1:0] sync_count_q;
	logic [2:0] band_count_q;
	logic tick_rise, ce_low, pd_now, wr_ctl, wr_fb, wr_ref;

	// True when the select bits of a word name the given latch.
	function automatic logic is_sel(input logic [23:0] w, input logic [1:0] code);
		return w[1:0] == code;
	endfunction

	serial_word_rx rx (
		.clock(clock),
		.reset_n(reset_n),
		.serial_clock(serial_clock),
		.serial_data(serial_data),
		.latch_strobe(latch_strobe),
		.wr(wr)
	);

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ce_sync_q <= 2'h0;
		end else begin
			ce_sync_q <= {ce_sync_q[0], chip_enable};
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tick_sync_q <= 2'h0;
			tick_prev_q <= 1'b0;
		end else begin
			tick_sync_q <= {tick_sync_q[0], ref_divider_tick};
			tick_prev_q <= tick_sync_q[1];
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			lock_sync_q <= 2'h0;
		end else begin
			lock_sync_q <= {lock_sync_q[0], lock_detect_raw};
		end
	end
	assign tick_rise = tick_sync_q[1] && !tick_prev_q;
	assign ce_low = !ce_sync_q[1];

	assign wr_ctl = wr.strobe && is_sel(wr.word, sel_control);
	assign wr_fb = wr.strobe && is_sel(wr.word, sel_feedback);
	assign wr_ref = wr.strobe && is_sel(wr.word, sel_reference);

	// control latch store
	// The pump gain bit is shared with the feedback latch; the latest write wins.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			control_word <= latch_reset;
		end else if (wr_ctl) begin
			control_word <= wr.word;
		end else if (wr_fb) begin
			control_word[ctl_pump_gain_pos] <= wr.word[fb_pump_gain_pos];
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			feedback_word <= latch_reset;
		end else if (wr_fb) begin
			feedback_word <= wr.word;
		end else if (wr_ctl) begin
			feedback_word[fb_pump_gain_pos] <= wr.word[ctl_pump_gain_pos];
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			reference_word <= latch_reset;
		end else if (wr_ref) begin
			reference_word <= wr.word;
		end
	end

	// control write wakes part
	// Until then the part stays unpowered, as right after supply-on.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			awake_q <= 1'b0;
		end else if (wr_ctl) begin
			awake_q <= 1'b1;
		end
	end

	// synchronous entry on second tick
	// Ticks count from the latch event, so a tick that arrives while the strobe
	// is still in the synchroniser is not counted.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pd_q <= pd_run;
			sync_count_q <= 2'h0;
		end else if (wr_ctl) begin
			sync_count_q <= 2'h0;
			if (!wr.word[ctl_pd_enable_pos]) begin
				pd_q <= pd_run;
			end else if (wr.word[ctl_pd_sync_pos]) begin
				pd_q <= (pd_q == pd_down) ? pd_down : pd_wait_sync;
			end else begin
				pd_q <= pd_down;
			end
		end else begin
			case (pd_q)
				pd_run: pd_q <= pd_run;
				pd_wait_sync: begin
					if (tick_rise) begin
						sync_count_q <= sync_count_q + 2'h1;
						if (sync_count_q + 2'h1 == sync_pd_edges) begin
							pd_q <= pd_down;
						end
					end
				end
				pd_down: pd_q <= pd_down;
				default: pd_q <= pd_run;
			endcase
		end
	end

	assign pd_now = ce_low || !awake_q || pd_q == pd_down;

	// Registered copy of the power-down state for the outside.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			powered_down <= 1'b1;
		end else begin
			powered_down <= pd_now;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			counters_load <= 1'b1;
		end else begin
			counters_load <= pd_now || control_word[ctl_counters_clear_pos];
		end
	end

	// pump tristate
	// The pump also floats while band selection holds the tune line.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pump_tristate <= 1'b1;
		end else begin
			pump_tristate <= pd_now || control_word[ctl_pump_tristate_pos] || band_pending_q;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			lock_detect <= 1'b0;
		end else begin
			lock_detect <= !pd_now && lock_sync_q[1];
		end
	end

	// RF outputs off
	// With mute until lock set, the outputs wait for a synced lock indication.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rf_output_enable <= 1'b0;
		end else begin
			rf_output_enable <= !pd_now &&
				(!control_word[ctl_mute_pos] || lock_sync_q[1]);
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ref_buffer_enable <= 1'b0;
		end else begin
			ref_buffer_enable <= !pd_now;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			band_pending_q <= 1'b0;
			band_count_q <= 3'h0;
		end else if (wr_fb) begin
			band_pending_q <= 1'b1;
			band_count_q <= 3'h0;
		end else if (band_pending_q && !pd_now && tick_rise) begin
			band_count_q <= band_count_q + 3'h1;
			if (band_count_q + 3'h1 == band_select_cycles) begin
				band_pending_q <= 1'b0;
			end
		end
	end

	// Field copies are registered so that every output leaves a flip-flop.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			band_select_busy <= 1'b0;
		end else begin
			band_select_busy <= band_pending_q && !pd_now;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			prescaler_sel <= 2'h0;
		end else begin
			prescaler_sel <= control_word[ctl_prescaler_pos +: 2];
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			b_count <= '0;
		end else begin
			b_count <= feedback_word[fb_b_pos +: fb_b_width];
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			a_count <= '0;
		end else begin
			a_count <= feedback_word[fb_a_pos +: fb_a_width];
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ref_divide <= '0;
		end else begin
			ref_divide <= reference_word[ref_div_pos +: ref_div_width];
		end
	end
endmodule

// ==== pkg/synth_pkg.sv ====
// Package for the synthesizer latch bank: field positions, select codes, timing.
// Assumes a 40 MHz system clock and a slow three-wire serial link from a host.
package synth_pkg;
	localparam int word_width = 24;
	localparam logic [1:0] sel_control = 2'h0;
	localparam logic [1:0] sel_reference = 2'h1;
	localparam logic [1:0] sel_feedback = 2'h2;
	localparam logic [1:0] sel_test = 2'h3;
	// Control latch fields.
	localparam int ctl_prescaler_pos = 22;
	localparam int ctl_pd_sync_pos = 21;
	localparam int ctl_pd_enable_pos = 20;
	localparam int ctl_current_two_pos = 17;
	localparam int ctl_current_one_pos = 14;
	localparam int ctl_out_power_pos = 12;
	localparam int ctl_mute_pos = 11;
	localparam int ctl_pump_gain_pos = 10;
	localparam int ctl_pump_tristate_pos = 9;
	localparam int ctl_polarity_pos = 8;
	localparam int ctl_mux_pos = 5;
	localparam int ctl_counters_clear_pos = 4;
	localparam int ctl_core_power_pos = 2;
	// Feedback latch fields.
	localparam int fb_source_pos = 23;
	localparam int fb_halve_pos = 22;
	localparam int fb_pump_gain_pos = 21;
	localparam int fb_b_pos = 8;
	localparam int fb_b_width = 13;
	localparam int fb_reserved_pos = 7;
	localparam int fb_a_pos = 2;
	localparam int fb_a_width = 5;
	// Reference latch fields.
	localparam int ref_band_div_pos = 20;
	localparam int ref_test_pos = 19;
	localparam int ref_precision_pos = 18;
	localparam int ref_backlash_pos = 16;
	localparam int ref_div_pos = 2;
	localparam int ref_div_width = 14;
	localparam logic [23:0] latch_reset = 24'h000000;
	// Number of reference-divider edges before a synchronous power-down takes effect.
	localparam logic [1:0] sync_pd_edges = 2'h2;
	// Band selection lasts this many detector cycles.
	localparam logic [2:0] band_select_cycles = 3'h5;
	typedef enum logic [1:0] {pd_run, pd_wait_sync, pd_down} pd_state_t;
endpackage

// ==== pkg/latch_write_if.sv ====
// Carries one completed 24-bit serial word from the receiver to the latch bank.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface latch_write_if;
	logic strobe;
	logic [23:0] word;
	modport source (output strobe, output word);
	modport sink (input strobe, input word);
endinterface

// ==== src/serial_word_rx.sv ====
// Three-wire serial receiver: samples the link on the system clock and
// shifts a word MSB first, presenting it on the latch strobe's rising edge.
// Assumes the serial clock is well below half the system clock rate.
`timescale 1ns/1ps
module serial_word_rx (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic serial_clock,
	input wire logic serial_data,
	input wire logic latch_strobe,
	latch_write_if.source wr
);
	import synth_pkg::*;
	logic [2:0] clk_meta_q, clk_sync_q;
	logic [2:0] in_meta_q;
	logic data_sync_q, strobe_sync_q, clk_prev_q, strobe_prev_q;
	logic [23:0] shift_q;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			in_meta_q <= 3'h0;
			clk_sync_q <= 3'h0;
		end else begin
			in_meta_q <= {serial_clock, serial_data, latch_strobe};
			clk_sync_q <= in_meta_q;
		end
	end
	assign clk_meta_q = clk_sync_q;
	assign data_sync_q = clk_meta_q[1];
	assign strobe_sync_q = clk_meta_q[0];

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			clk_prev_q <= 1'b0;
			strobe_prev_q <= 1'b0;
		end else begin
			clk_prev_q <= clk_meta_q[2];
			strobe_prev_q <= strobe_sync_q;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			shift_q <= latch_reset;
		end else if (clk_meta_q[2] && !clk_prev_q) begin
			shift_q <= {shift_q[22:0], data_sync_q};
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			wr.strobe <= 1'b0;
			wr.word <= latch_reset;
		end else begin
			wr.strobe <= strobe_sync_q && !strobe_prev_q;
			wr.word <= shift_q;
		end
	end
endmodule

// ==== sim/host_link_model.sv ====
// Host model that drives the three-wire link with one 24-bit word for each latch write.
// Assumes a 200 ns link clock that stands low between words.
`timescale 1ns/1ps
module host_link_model (
	output logic serial_clock,
	output logic serial_data,
	output logic latch_strobe
);
	initial begin
		serial_clock = 1'b0;
		serial_data = 1'b0;
		latch_strobe = 1'b0;
	end
	task send(input logic [23:0] word);
		for (int i = 23; i >= 0; i--) begin
			serial_data = word[i];
			#100 serial_clock = 1'b1;
			#100 serial_clock = 1'b0;
		end
		// The data line shows the inverse of the last bit, so a stale bit never looks held.
		serial_data = ~word[0];
		#100 latch_strobe = 1'b1;
		#200 latch_strobe = 1'b0;
		#100;
	endtask
endmodule

// ==== sim/synth_latch_powerdown_ctrl_asserts.sv ====
// Checker for the latch bank: power-down side effects and latch steering.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module synth_latch_checker (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic chip_enable,
	input wire logic [23:0] control_word,
	input wire logic [23:0] feedback_word,
	input wire logic powered_down,
	input wire logic counters_load,
	input wire logic pump_tristate,
	input wire logic lock_detect,
	input wire logic rf_output_enable,
	input wire logic ref_buffer_enable,
	input wire logic band_select_busy,
	input wire logic [synth_pkg::fb_b_width-1:0] b_count,
	input wire logic [synth_pkg::fb_a_width-1:0] a_count
);
	import synth_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	sequence pd_held;
		powered_down [*2];
	endsequence
	sequence ctl_async_latched;
		$changed(control_word) && control_word[21:20] == 2'h1;
	endsequence
	a_counters_load_pd: assert property (pd_held |-> counters_load)
		else $error("counters not in load state");
	a_pump_tristate_pd: assert property (pd_held |-> pump_tristate)
		else $error("pump not tristate");
	a_lock_cleared_pd: assert property (pd_held |-> !lock_detect)
		else $error("lock detect not cleared");
	a_outputs_off_pd: assert property (pd_held |-> !rf_output_enable && !ref_buffer_enable)
		else $error("outputs still enabled");
	a_ce_forces_pd: assert property (!chip_enable [*5] |-> powered_down)
		else $error("chip enable low ignored");
	a_async_pd_now: assert property (ctl_async_latched |-> ##[0:1] powered_down)
		else $error("async power-down late");
	a_ctl_select: assert property ($changed(control_word) |-> control_word[1:0] == sel_control)
		else $error("control latch took a wrong word");
	a_fb_select: assert property ($changed(feedback_word[20:2]) |-> feedback_word[1:0] == sel_feedback)
		else $error("feedback latch took a wrong word");
	a_fb_fields: assert property ($stable(feedback_word) |->
		b_count == feedback_word[20:8] && a_count == feedback_word[6:2])
		else $error("counter fields mismatch");
	a_band_start: assert property ($changed(feedback_word[20:2]) && !powered_down
		|-> ##[0:2] band_select_busy)
		else $error("band select not started");
endmodule
bind synth_latch_powerdown_ctrl synth_latch_checker i_chk (
	.clock(clock),
	.reset_n(reset_n),
	.chip_enable(chip_enable),
	.control_word(control_word),
	.feedback_word(feedback_word),
	.powered_down(powered_down),
	.counters_load(counters_load),
	.pump_tristate(pump_tristate),
	.lock_detect(lock_detect),
	.rf_output_enable(rf_output_enable),
	.ref_buffer_enable(ref_buffer_enable),
	.band_select_busy(band_select_busy),
	.b_count(b_count),
	.a_count(a_count)
);

// ==== sim/testbench.sv ====
// Testbench for the latch bank: programs latches and power-down modes over the link.
// Assumes the host model drives the link and the checker is bound to the design.
`timescale 1ns/1ps
module testbench;
	import synth_pkg::*;
	logic clock, reset_n, chip_enable, ref_divider_tick, lock_detect_raw;
	logic serial_clock, serial_data, latch_strobe;
	logic [23:0] control_word, feedback_word, reference_word;
	logic powered_down, counters_load, pump_tristate, lock_detect;
	logic rf_output_enable, ref_buffer_enable, band_select_busy;
	logic [1:0] prescaler_sel;
	logic [fb_b_width-1:0] b_count;
	logic [fb_a_width-1:0] a_count;
	logic [ref_div_width-1:0] ref_divide;
	int miscompares = 0;
	int checked = 0;
	host_link_model i_host (.serial_clock(serial_clock), .serial_data(serial_data),
		.latch_strobe(latch_strobe));
	synth_latch_powerdown_ctrl i_dut (
		.clock(clock),
		.reset_n(reset_n),
		.serial_clock(serial_clock),
		.serial_data(serial_data),
		.latch_strobe(latch_strobe),
		.chip_enable(chip_enable),
		.ref_divider_tick(ref_divider_tick),
		.lock_detect_raw(lock_detect_raw),
		.control_word(control_word),
		.feedback_word(feedback_word),
		.reference_word(reference_word),
		.powered_down(powered_down),
		.counters_load(counters_load),
		.pump_tristate(pump_tristate),
		.lock_detect(lock_detect),
		.rf_output_enable(rf_output_enable),
		.ref_buffer_enable(ref_buffer_enable),
		.band_select_busy(band_select_busy),
		.prescaler_sel(prescaler_sel),
		.b_count(b_count),
		.a_count(a_count),
		.ref_divide(ref_divide)
	);
	task chk(input logic [23:0] got, input logic [23:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task clk(input int n);
		repeat (n) @(posedge clock);
		#2;
	endtask
	// One reference divider period, long enough for the synchronizer.
	task tick;
		repeat (2) begin
			clk(4);
			ref_divider_tick = ~ref_divider_tick;
		end
	endtask
	task results;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	initial begin
		#2000000;
		miscompares++;
		results();
	end
	initial begin
		reset_n = 1'b0;
		chip_enable = 1'b1;
		ref_divider_tick = 1'b0;
		lock_detect_raw = 1'b0;
		clk(3);
		reset_n = 1'b1;
		chk(powered_down, 1'b1);
		i_host.send(24'h00048d);
		chk(reference_word, 24'h00048d);
		chk(ref_divide, 14'h0123);
		i_host.send(24'h400004);
		chk(powered_down, 1'b0);
		chk(prescaler_sel, 2'h1);
		chk(rf_output_enable, 1'b1);
		#600000;
		i_host.send(24'h00100e);
		chk(feedback_word, 24'h00100e);
		chk(b_count, 13'h0010);
		chk(a_count, 5'h03);
		chk(band_select_busy, 1'b1);
		repeat (5) tick();
		clk(4);
		chk(band_select_busy, 1'b0);
		$display("test power-up done");
		lock_detect_raw = 1'b1;
		i_host.send(24'hffffff);
		chk(control_word, 24'h400004);
		chk(feedback_word, 24'h00100e);
		chk(reference_word, 24'h00048d);
		chk(lock_detect, 1'b1);
		$display("test select done");
		lock_detect_raw = 1'b0;
		i_host.send(24'h400e14);
		chk(rf_output_enable, 1'b0);
		chk(pump_tristate, 1'b1);
		chk(counters_load, 1'b1);
		chk(feedback_word, 24'h20100e);
		lock_detect_raw = 1'b1;
		clk(4);
		chk(rf_output_enable, 1'b1);
		$display("test flags done");
		i_host.send(24'h500004);
		chk(powered_down, 1'b1);
		chk(counters_load, 1'b1);
		chk(pump_tristate, 1'b1);
		chk(lock_detect, 1'b0);
		chk({rf_output_enable, ref_buffer_enable}, 2'h0);
		i_host.send(24'h000ffd);
		chk(ref_divide, 14'h03ff);
		i_host.send(24'h400004);
		chk(powered_down, 1'b0);
		chk(feedback_word, 24'h00100e);
		chk(band_select_busy, 1'b0);
		$display("test async done");
		i_host.send(24'h700004);
		chk(powered_down, 1'b0);
		tick();
		chk(powered_down, 1'b0);
		tick();
		clk(3);
		chk(powered_down, 1'b1);
		$display("test sync done");
		i_host.send(24'h400004);
		chip_enable = 1'b0;
		clk(6);
		chk(powered_down, 1'b1);
		chip_enable = 1'b1;
		clk(6);
		chk(powered_down, 1'b0);
		$display("test chip enable done");
		results();
	end
endmodule
